// *** inc/prd_pkg.sv ***
package prd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_MODSEL  = 12'h004;
   localparam logic [11:0] OFS_STATUS  = 12'h008;
   localparam logic [11:0] OFS_MEAS    = 12'h00C;
   localparam logic [11:0] OFS_NVAL_LO = 12'h010;
   localparam logic [11:0] OFS_NVAL_HI = 12'h014;
   localparam logic [11:0] OFS_RATIO0  = 12'h020;
   localparam logic [11:0] OFS_RATIO3  = 12'h02C;

   // Control register field positions
   localparam int unsigned CTRL_REFDIV_LSB = 0;
   localparam int unsigned CTRL_BW_LSB     = 2;
   localparam int unsigned CTRL_FMT_BIT    = 5;
   localparam int unsigned CTRL_FN_LSB     = 8;

   // Status register field positions
   localparam int unsigned STAT_LOCK_BIT = 0;
   localparam int unsigned STAT_WIDE_BIT = 1;
   localparam int unsigned STAT_MODE_LSB = 2;
   localparam int unsigned STAT_RMOD_BIT = 4;

   // Values after reset
   localparam logic [1:0]  REFDIV_RESET = 2'h0;
   localparam logic [2:0]  BW_RESET     = 3'h0;
   localparam logic        FMT_RESET    = 1'b0;
   localparam logic [2:0]  FN_RESET     = 3'h0;
   localparam logic [7:0]  MODSEL_RESET = 8'h00;
   localparam logic [31:0] RATIO_RESET  = 32'h0010_0000;

   // Third mode pin function code that enables the ratio modifier
   localparam logic [2:0] FN_RMOD_EN = 3'h3;

   // Ratio formats
   localparam logic FMT_HIGH_RES  = 1'b0;
   localparam logic FMT_HIGH_MULT = 1'b1;

   // Digital loop numbers
   localparam int unsigned FRAC_W = 20;
   localparam int unsigned NVAL_W = 40;
   localparam int unsigned MEAS_W = 24;
   localparam logic [3:0]  ACQ_SHIFT   = 4'h2;
   localparam logic [3:0]  MINBW_SHIFT = 4'hE;
   localparam logic [2:0]  LOCK_RUNS   = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // APB request and answer
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } prd_apb_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } prd_apb_rsp_s;

   // Digital loop phase
   typedef enum logic [1:0] {
      LOOP_ACQUIRE = 2'b01,
      LOOP_TRACK   = 2'b10
   } prd_loop_e;

endpackage

// *** hw/prd_sync.sv ***
module prd_sync
   import prd_pkg::*;
#(
   parameter int unsigned WIDTH = 5
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Asynchronous inputs
   input  wire logic [WIDTH-1:0] async_in,
   // Filtered level and rising-edge pulse
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] rise;
   } prd_sync_s;

   prd_sync_s st;
   prd_sync_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Level changes only once stages two and three agree; s1 feeds s2 only
   always_comb begin
      next_st    = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s3[i];
         end
      end
      next_st.rise = next_st.lvl & ~st.lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.lvl;
   assign rise  = st.rise;

endmodule // prd_sync

// *** hw/prd_ref_div.sv ***
module prd_ref_div
   import prd_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Divider ratio select: 1, 2, 4 or 8
   input  wire logic [1:0] reference_divider_select,
   // One-cycle enable at the divided rate
   output logic            internal_system_clock
);

   typedef struct packed {
      logic [2:0] cnt;
      logic       en;
   } prd_div_s;

   prd_div_s   st;
   prd_div_s   next_st;
   logic [2:0] last;

   ////////////////////////////////////////////////////////////////////////
   // Terminal count follows the select; a counter already past a smaller
   // select wraps on the next cycle, so it never runs on to 7 first
   always_comb begin
      last    = 3'((4'h1 << reference_divider_select) - 4'h1);
      next_st = st;
      if (st.cnt >= last) begin
         next_st.cnt = 3'h0;
         next_st.en  = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 3'h1;
         next_st.en  = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign internal_system_clock = st.en;

endmodule // prd_ref_div

// *** hw/prd_ratio_ctrl.sv ***
// Operation
// - System clock enable from divided reference clock
// - Measure output edges per reference period
// - Convert ratio to system-clock based value
// - Minimum loop bandwidth select, 1-128 Hz
// - Loop passes slow jitter, filters fast
// - Wide bandwidth acquiring, minimum once locked
// - User ratios are 32-bit unsigned fixed-point
// - Four ratios, mode pins pick one
// - One format bit selects 12.20/20.12
// - 12.20: twelve integer, twenty fraction bits
// - 20.12: twenty integer, twelve fraction bits
// - Internal dividers compensated automatically
// - Modifier scales selected ratio, stored unchanged
// - Modifier enabled only by third pin function
// - Select 00..11 gives 1/2 to 1/16
// - Effective ratio is ratio times factor
// - Third pin high enables, low disables modifier
// - Mode pin change drops lock
module prd_ratio_ctrl
   import prd_pkg::*;
(
   // Clock and reset (pclk is the timing reference clock)
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire prd_apb_req_s      apb_req,
   output prd_apb_rsp_s           apb_rsp,
   // Pins
   input  wire logic              freq_ref_in,
   input  wire logic              pll_out_in,
   input  wire logic [1:0]        mode_select,
   input  wire logic              third_mode_pin,
   // Synthesizer side
   output logic [NVAL_W-1:0]      frac_n_value,
   output logic                   pll_locked,
   output logic                   internal_system_clock
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [1:0]            refdiv;
      logic [2:0]            bw;
      logic                  fmt;
      logic [2:0]            fn;
      logic [7:0]            modsel;
      logic [3:0][31:0]      ratio;
      logic [31:0]           rdata;
      prd_loop_e             loop;
      logic [MEAS_W-1:0]     pll_cnt;
      logic [MEAS_W-1:0]     meas;
      logic                  meas_new;
      logic [NVAL_W-1:0]     nval;
      logic [2:0]            runs;
      logic [1:0]            mode_q;
      logic                  seeded;
   } prd_ctrl_s;

   prd_ctrl_s st;
   prd_ctrl_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Decoding used by both the write and the read path
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == OFS_CTRL)    || (a == OFS_MODSEL)  ||
                (a == OFS_STATUS)  || (a == OFS_MEAS)    ||
                (a == OFS_NVAL_LO) || (a == OFS_NVAL_HI) ||
                ((a >= OFS_RATIO0) && (a <= OFS_RATIO3) &&
                 (a[1:0] == 2'h0));
   endfunction

   function automatic logic is_ratio(input logic [ADDR_W-1:0] a);
      is_ratio = (a >= OFS_RATIO0) && (a <= OFS_RATIO3);
   endfunction

   // Bring either format to a common 20.20 value
   function automatic logic [NVAL_W-1:0] to_fixed(
      input logic [31:0] r,
      input logic        fmt
   );
      if (fmt == FMT_HIGH_MULT) begin
         to_fixed = {r, 8'h00};
      end else begin
         to_fixed = {8'h00, r};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Synchronised pins: freq_ref, pll_out, mode[1:0], third pin
   logic [4:0] pin_lvl;
   logic [4:0] pin_rise;

   prd_sync #(
      .WIDTH    (5)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({third_mode_pin, mode_select, pll_out_in, freq_ref_in}),
      .level    (pin_lvl),
      .rise     (pin_rise)
   );

   logic       ref_edge;
   logic       out_edge;
   logic [1:0] mode_lvl;
   logic       third_pin_lvl;

   assign ref_edge = pin_rise[0];
   assign out_edge = pin_rise[1];
   assign mode_lvl = pin_lvl[3:2];
   assign third_pin_lvl = pin_lvl[4];

   ////////////////////////////////////////////////////////////////////////
   // Internal system clock enable
   logic sys_en;

   prd_ref_div u_div (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .reference_divider_select (st.refdiv),
      .internal_system_clock    (sys_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // Ratio selection and modifier
   logic                      rmod_on;
   logic [1:0]                mod_sel;
   logic [31:0]               user_ratio;
   logic [NVAL_W-1:0]         base_ratio;
   logic [NVAL_W-1:0]         effective_ratio;

   always_comb begin
      // Modifier only through the third pin in its enable function
      rmod_on    = (st.fn == FN_RMOD_EN) && third_pin_lvl;
      // Set now on the pins, so a reseed on a mode change takes the new set
      mod_sel    = st.modsel[2*mode_lvl +: 2];
      user_ratio = st.ratio[mode_lvl];
      base_ratio = to_fixed(user_ratio, st.fmt);
      if (rmod_on) begin
         // Factor 2^-(sel+1); widened so the 1/16 code cannot wrap to 0
         effective_ratio = base_ratio >> (3'(mod_sel) + 3'h1);
      end else begin
         effective_ratio = base_ratio;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Loop error against the measured count
   logic signed [NVAL_W:0]   loop_err;
   logic signed [NVAL_W:0]   loop_step;
   logic [NVAL_W:0]          err_mag;
   logic                     err_small;
   logic [3:0]               loop_shift;

   always_comb begin
      // Target pll edges per reference period versus what was counted
      loop_err  = $signed({1'b0, effective_ratio}) -
                  $signed({1'b0, st.meas[FRAC_W-1:0],
                           {FRAC_W{1'b0}}});
      err_mag   = loop_err[NVAL_W] ? (NVAL_W+1)'(0) - loop_err : loop_err;
      err_small = err_mag < (NVAL_W+1)'(1) << FRAC_W;
      // Small shift = wide loop; large shift = narrow loop
      if (st.loop == LOOP_ACQUIRE) begin
         loop_shift = ACQ_SHIFT;
      end else begin
         loop_shift = MINBW_SHIFT - {1'b0, st.bw};
      end
      // Slow wander follows through, fast jitter is averaged out
      loop_step = loop_err >>> loop_shift;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB phases
   logic setup_ph;
   logic wr_acc;
   logic [ADDR_W-1:0] a;

   assign a        = apb_req.paddr;
   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                     reg_hit(a);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;

      // Register writes take effect in the access phase
      if (wr_acc) begin
         if (a == OFS_CTRL) begin
            next_st.refdiv = apb_req.pwdata[CTRL_REFDIV_LSB +: 2];
            next_st.bw     = apb_req.pwdata[CTRL_BW_LSB +: 3];
            next_st.fmt    = apb_req.pwdata[CTRL_FMT_BIT];
            next_st.fn     = apb_req.pwdata[CTRL_FN_LSB +: 3];
         end
         if (a == OFS_MODSEL) begin
            next_st.modsel = apb_req.pwdata[7:0];
         end
         if (is_ratio(a)) begin
            next_st.ratio[a[3:2]] = apb_req.pwdata;
         end
      end

      // Read data captured in setup so prdata comes from a flip-flop
      if (setup_ph) begin
         next_st.rdata = 32'h0000_0000;
         if (a == OFS_CTRL) begin
            next_st.rdata[CTRL_REFDIV_LSB +: 2] = st.refdiv;
            next_st.rdata[CTRL_BW_LSB +: 3]     = st.bw;
            next_st.rdata[CTRL_FMT_BIT]         = st.fmt;
            next_st.rdata[CTRL_FN_LSB +: 3]     = st.fn;
         end
         if (a == OFS_MODSEL) begin
            next_st.rdata[7:0] = st.modsel;
         end
         if (a == OFS_STATUS) begin
            next_st.rdata[STAT_LOCK_BIT]     = st.loop == LOOP_TRACK;
            next_st.rdata[STAT_WIDE_BIT]     = st.loop == LOOP_ACQUIRE;
            next_st.rdata[STAT_MODE_LSB +: 2] = st.mode_q;
            next_st.rdata[STAT_RMOD_BIT]     = rmod_on;
         end
         if (a == OFS_MEAS) begin
            next_st.rdata[MEAS_W-1:0] = st.meas;
         end
         if (a == OFS_NVAL_LO) begin
            next_st.rdata = st.nval[31:0];
         end
         if (a == OFS_NVAL_HI) begin
            next_st.rdata[NVAL_W-33:0] = st.nval[NVAL_W-1:32];
         end
         if (is_ratio(a) && reg_hit(a)) begin
            next_st.rdata = st.ratio[a[3:2]];
         end
      end

      // Output edges between reference edges give the actual ratio
      if (ref_edge) begin
         next_st.meas     = st.pll_cnt + MEAS_W'(out_edge);
         next_st.pll_cnt  = '0;
         next_st.meas_new = st.seeded;
         next_st.seeded   = 1'b1;
      end else if (out_edge && (st.pll_cnt != '1)) begin
         next_st.pll_cnt = st.pll_cnt + MEAS_W'(1);
      end

      // Loop update paced by the internal system clock; the loop closes
      // through the output itself, so the divider needs no correction
      if (sys_en && st.meas_new && !ref_edge) begin
         next_st.meas_new = 1'b0;
         next_st.nval = st.nval + loop_step[NVAL_W-1:0];
         unique case (st.loop)
            LOOP_ACQUIRE: begin
               if (!err_small) begin
                  next_st.runs = 3'h0;
               end else if (st.runs == LOCK_RUNS - 3'h1) begin
                  next_st.loop = LOOP_TRACK;
                  next_st.runs = 3'h0;
               end else begin
                  next_st.runs = st.runs + 3'h1;
               end
            end
            LOOP_TRACK: begin
               // Gross error means lock was lost: widen again
               if (!err_small) begin
                  next_st.loop = LOOP_ACQUIRE;
               end
            end
         endcase
      end

      // A mode change reseeds the loop and drops lock
      if (mode_lvl != st.mode_q) begin
         next_st.mode_q   = mode_lvl;
         next_st.loop     = LOOP_ACQUIRE;
         next_st.runs     = 3'h0;
         next_st.meas_new = 1'b0;
         next_st.seeded   = 1'b0;
         next_st.nval     = effective_ratio;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.refdiv   <= REFDIV_RESET;
         st.bw       <= BW_RESET;
         st.fmt      <= FMT_RESET;
         st.fn       <= FN_RESET;
         st.modsel   <= MODSEL_RESET;
         st.ratio    <= {4{RATIO_RESET}};
         st.rdata    <= 32'h0000_0000;
         st.loop     <= LOOP_ACQUIRE;
         st.pll_cnt  <= '0;
         st.meas     <= '0;
         st.meas_new <= 1'b0;
         st.nval     <= {8'h00, RATIO_RESET};
         st.runs     <= 3'h0;
         st.mode_q   <= 2'h0;
         st.seeded   <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign apb_rsp.prdata  = st.rdata;
   assign apb_rsp.pready  = 1'b1; // Zero wait states
   // Unmapped or misaligned words answer with an error
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !reg_hit(a);

   assign frac_n_value          = st.nval;
   assign pll_locked            = st.loop == LOOP_TRACK;
   assign internal_system_clock = sys_en;

endmodule // prd_ratio_ctrl

// *** tb/prd_ratio_ctrl_asserts.sv ***
module prd_ratio_ctrl_asserts
   import prd_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Register bus
   input wire prd_apb_req_s      apb_req,
   input wire prd_apb_rsp_s      apb_rsp,
   // Pins
   input wire logic              freq_ref_in,
   input wire logic              pll_out_in,
   input wire logic [1:0]        mode_select,
   input wire logic              third_mode_pin,
   // Synthesizer side
   input wire logic [NVAL_W-1:0] frac_n_value,
   input wire logic              pll_locked,
   input wire logic              internal_system_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////
   logic        wr_ctrl;
   logic [10:0] ctrl_sh;
   logic [3:0]  gap;
   logic        gap_ok;
   assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite
                    && apb_req.paddr == OFS_CTRL;

   // Shadow of control and pulse spacing; a gap spanning a write is skipped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_sh <= 11'h000;
         gap <= 4'h0;
         gap_ok <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_sh <= apb_req.pwdata[10:0] & 11'h73F;
            gap_ok <= 1'b0;
         end else if (internal_system_clock) begin
            gap_ok <= 1'b1;
         end
         gap <= internal_system_clock ? 4'h1 : gap + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////
   sequence s_access;
      apb_req.psel && apb_req.penable;
   endsequence

   a_ready_high: assert property (s_access |-> apb_rsp.pready)
      else $error("pready low in access phase");
   a_err_access: assert property (
      apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
      else $error("pslverr outside access phase");
   a_bad_addr: assert property (
      s_access ##0 apb_req.paddr == 12'h018 |-> apb_rsp.pslverr)
      else $error("unmapped address not refused");
   a_ctrl_readback: assert property (
      s_access ##0 (!apb_req.pwrite && apb_req.paddr == OFS_CTRL)
      |-> (apb_rsp.prdata & 32'h0000_073F) == {21'h0, ctrl_sh})
      else $error("control read differs from last write");
   a_div_gap: assert property (
      internal_system_clock && gap_ok |-> gap == (4'h1 << ctrl_sh[1:0]))
      else $error("system clock spacing wrong");
   a_mode_unlock: assert property (
      $changed(mode_select) |-> ##[1:6] !pll_locked)
      else $error("lock kept after mode change");
   a_unlock_hold: assert property (
      $fell(pll_locked) |=> !pll_locked [*4])
      else $error("lock regained too soon");
   a_reset_seed: assert property (
      $rose(presetn) |-> frac_n_value == 40'h00_0010_0000 && !pll_locked)
      else $error("wrong value after reset");
endmodule // prd_ratio_ctrl_asserts

// *** tb/prd_clk_src.sv ***
module prd_clk_src
   import prd_pkg::*;
#(
   parameter int REF_HALF = 2000,
   parameter int OUT_HALF = 20
) (
   // Run control
   input  wire logic run,
   // Clocks towards the block
   output logic      freq_ref,
   output logic      pll_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_raw = 1'b0;
   logic out_raw = 1'b0;

   // Offset by 3 ns so no edge lands on a pclk edge
   initial #3 forever #(REF_HALF) ref_raw = ~ref_raw;
   initial #3 forever #(OUT_HALF) out_raw = ~out_raw;
   // Both clocks stand low outside a run
   assign freq_ref = run & ref_raw;
   assign pll_out = run & out_raw;
endmodule // prd_clk_src

// *** tb/test_pll_ratio_select_and_reference_divider.sv ***
module test_pll_ratio_select_and_reference_divider
   import prd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              pclk;
   logic              presetn;
   prd_apb_req_s      req;
   prd_apb_rsp_s      rsp;
   logic              run;
   logic [1:0]        mode_select;
   logic              third_mode_pin;
   logic              freq_ref_in;
   logic              pll_out_in;
   logic [NVAL_W-1:0] frac_n_value;
   logic              pll_locked;
   logic              sys_en;
   int                err_count = 0;
   int                comparisons = 0;
   int                cyc = 0;
   // Low nibble clear so a 1/16 scale truncates nothing
   logic [31:0] rt [4] = '{32'h0640_0000, 32'h0123_4560, 32'h8000_0010,
                           32'hFFFF_FFF0};

   ////////////////////////////////////////////////////////////
   prd_ratio_ctrl i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .freq_ref_in(freq_ref_in), .pll_out_in(pll_out_in),
      .mode_select(mode_select), .third_mode_pin(third_mode_pin),
      .frac_n_value(frac_n_value), .pll_locked(pll_locked),
      .internal_system_clock(sys_en));
   prd_clk_src i_src (.run(run), .freq_ref(freq_ref_in),
      .pll_out(pll_out_in));

   // Clock and cycle count
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One transfer; starts on the next edge so strobes never clash
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask
   // Leave and re-enter a mode so the loop reseeds, then read the value
   task automatic nval(logic [1:0] m, logic [39:0] e,
                       output logic [39:0] v);
      logic [31:0] lo;
      logic [31:0] hi;
      mode_select <= ~m;
      repeat (10) @(posedge pclk);
      mode_select <= m;
      repeat (10) @(posedge pclk);
      check("nval_port", frac_n_value, e);
      rd(OFS_NVAL_LO, lo);
      rd(OFS_NVAL_HI, hi);
      v = {hi[7:0], lo};
      check("nval_pin", frac_n_value, v);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 4; i++) begin
         rd(OFS_RATIO0 + 12'(4 * i), q);
         check("ratio_rst", q, RATIO_RESET);
         wr(OFS_RATIO0 + 12'(4 * i), rt[i]);
      end
      apb(1'b1, 12'h018, 32'hFFFF_FFFF, q, e);
      check("unmapped", e, 1'b1);
   endtask
   task automatic t_div;
      logic [31:0] q;
      int          t0;
      for (int d = 0; d < 4; d++) begin
         wr(OFS_CTRL, 32'(d));
         rd(OFS_CTRL, q);
         check("ctrl_rb", q, 32'(d));
         repeat (20) @(posedge pclk);
         do @(posedge pclk); while (sys_en !== 1'b1);
         t0 = cyc;
         do @(posedge pclk); while (sys_en !== 1'b1);
         check("div_gap", 40'(cyc - t0), 40'(1 << d));
      end
   endtask
   // Every format, mode and modifier code; modifier off by function, off by pin low, and on
   task automatic t_ratio;
      logic [39:0] v;
      logic [39:0] e;
      logic [31:0] q;
      wr(OFS_MODSEL, 32'h0000_00E4);
      for (int f = 0; f < 2; f++) for (int p = 0; p < 3; p++)
         for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, {21'h0, (p > 0) ? FN_RMOD_EN : 3'(m + 4), 2'h0,
                          1'(f), 5'h00});
            third_mode_pin <= (p != 1);
            e = f ? {rt[m], 8'h00} : {8'h00, rt[m]};
            if (p == 2) e = e >> (m + 1);
            nval(2'(m), e, v);
            check("eff_ratio", v, e);
            rd(OFS_STATUS, q);
            check("stat_mode", q[4:2], {p == 2, 2'(m)});
            rd(OFS_RATIO0 + 12'(4 * m), q);
            check("ratio_kept", q, rt[m]);
         end
   endtask
   task automatic t_lock;
      logic [31:0] q;
      logic [39:0] v;
      third_mode_pin <= 1'b0;
      wr(OFS_CTRL, 32'h0000_001C);
      nval(2'b00, {8'h00, rt[0]}, v);
      rd(OFS_STATUS, q);
      check("acquire", q[1:0], 2'b10);
      run <= 1'b1;
      for (int n = 0; n < 20000 && pll_locked !== 1'b1; n++)
         @(posedge pclk);
      check("locked", pll_locked, 1'b1);
      rd(OFS_MEAS, q);
      check("meas", q, 32'h0000_0064);
      rd(OFS_STATUS, q);
      check("track", q[1:0], 2'b01);
      mode_select <= 2'b01;
      repeat (10) @(posedge pclk);
      check("unlock", pll_locked, 1'b0);
      run <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      presetn = 1'b0;
      req = '0;
      run = 1'b0;
      mode_select = 2'b00;
      third_mode_pin = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_div();
      t_ratio();
      t_lock();
      final_report();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge pclk);
      err_count++;
      final_report();
   end
endmodule // test_pll_ratio_select_and_reference_divider

bind prd_ratio_ctrl prd_ratio_ctrl_asserts i_chk (.pclk(pclk),
   .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .freq_ref_in(freq_ref_in), .pll_out_in(pll_out_in),
   .mode_select(mode_select), .third_mode_pin(third_mode_pin),
   .frac_n_value(frac_n_value), .pll_locked(pll_locked),
   .internal_system_clock(internal_system_clock));
